// >>> include/amux_defs.svh
// Functional notes
// - Port one pins reset to address function
// - Port one pull-up bit clear disables pull-up
// - Port two pull-up bit clear disables pull-up
// - Drive-keep bit decides tri-state on idle bus
// - Boot straps pick port two low function
// - Software may always rewrite port two function
// - Port two upper pins reset as GPIO
// - Upper pins monitor four internal clocks
// - Per-pin release of GPIO on port two
// - Clock-select field picks address or clock
// - GPIO pins individually input or output
`ifndef AMUX_DEFS_SVH
`define AMUX_DEFS_SVH

`define AMUX_ADDR_W          4
`define AMUX_DATA_W          16
`define AMUX_PORT_W          8
`define AMUX_PIN_CNT         16
`define AMUX_UPPER_W         4

`define AMUX_OFS_P1_PULLUP   4'h0
`define AMUX_OFS_P1_DIR      4'h1
`define AMUX_OFS_P1_DATA     4'h2
`define AMUX_OFS_P1_PERIPH   4'h3
`define AMUX_OFS_P1_PINS     4'h4
`define AMUX_OFS_P2_PULLUP   4'h5
`define AMUX_OFS_P2_DIR      4'h6
`define AMUX_OFS_P2_DATA     4'h7
`define AMUX_OFS_P2_PERIPH   4'h8
`define AMUX_OFS_P2_PINS     4'h9
`define AMUX_OFS_BUS_CTRL    4'hA
`define AMUX_OFS_CLK_SEL     4'hB

`define AMUX_PULLUP_RST      8'hFF
`define AMUX_DIR_RST         8'h00
`define AMUX_DATA_RST        8'h00
`define AMUX_P1_PERIPH_RST   8'hFF
`define AMUX_P2_UPPER_RST    4'h0
`define AMUX_P2_LOWER_RST    4'h0
`define AMUX_CLK_SEL_RST     4'h0
`define AMUX_DRV_BIT         0
`define AMUX_DRV_RST         1'b0
`define AMUX_RD_ZERO         16'h0000

`endif

// >>> include/amux_pkg.sv
package amux_pkg;
    typedef enum logic [1:0] {
        FUNC_GPIO,
        FUNC_ADDR,
        FUNC_CLK
    } amux_func_t;

    typedef enum logic {
        BOOT_PENDING,
        BOOT_DONE
    } amux_boot_t;
endpackage

// >>> include/amux_pin_if.sv
interface amux_pin_if;
    amux_pkg::amux_func_t func;
    logic                 addrBit;
    logic                 addrDrive;
    logic                 clkBit;
    logic                 gpioDir;
    logic                 gpioData;
    logic                 pullCtrl;
    logic                 pinOut;
    logic                 pinOe;
    logic                 pullOn;

    modport ctrl (
        output func,
        output addrBit,
        output addrDrive,
        output clkBit,
        output gpioDir,
        output gpioData,
        output pullCtrl,
        input  pinOut,
        input  pinOe,
        input  pullOn
    );

    modport slice (
        input  func,
        input  addrBit,
        input  addrDrive,
        input  clkBit,
        input  gpioDir,
        input  gpioData,
        input  pullCtrl,
        output pinOut,
        output pinOe,
        output pullOn
    );
endinterface

// >>> logic/amux_pin_slice.sv
`include "amux_defs.svh"

module amux_pin_slice (
    input wire logic   clock,
    input wire logic   rst_n,
    amux_pin_if.slice  pin
);
    logic pinOut_reg;
    logic pinOe_reg;
    logic pullOn_reg;
    logic pinOut_next;
    logic pinOe_next;

    // Alternate functions take the pad away from the GPIO settings
    always_comb begin
        case (pin.func)
            amux_pkg::FUNC_ADDR: begin
                pinOut_next = pin.addrBit;
                pinOe_next  = pin.addrDrive;
            end
            amux_pkg::FUNC_CLK: begin
                pinOut_next = pin.clkBit;
                pinOe_next  = 1'b1;
            end
            default: begin
                pinOut_next = pin.gpioData;
                pinOe_next  = pin.gpioDir;
            end
        endcase
    end

    // Output disabled and pull-up on while in reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pinOut_reg <= 1'b0;
            pinOe_reg  <= 1'b0;
            pullOn_reg <= 1'b1;
        end else begin
            pinOut_reg <= pinOut_next;
            pinOe_reg  <= pinOe_next;
            pullOn_reg <= pin.pullCtrl;
        end
    end

    assign pin.pinOut = pinOut_reg;
    assign pin.pinOe  = pinOe_reg;
    assign pin.pullOn = pullOn_reg;
endmodule // amux_pin_slice

// >>> logic/amux_pin_mux.sv
// Our own choices: the address-and-strobe port and the register addresses.
`include "amux_defs.svh"

module amux_pin_mux #(
    parameter int PORT_W  = `AMUX_PORT_W,
    parameter int UPPER_W = `AMUX_UPPER_W
) (
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire logic [`AMUX_ADDR_W-1:0]    regAddr,
    input  wire logic [`AMUX_DATA_W-1:0]    regWrData,
    input  wire logic                       regWrite,
    input  wire logic                       regRead,
    output logic      [`AMUX_DATA_W-1:0]    regRdData,
    input  wire logic [23:8]                extAddr,
    input  wire logic                       extBusActive,
    input  wire logic                       external_boot_input,
    input  wire logic                       ext_bus_mode_input,
    input  wire logic                       flashSecured,
    input  wire logic                       prescalerClk,
    input  wire logic                       system_clk_main,
    input  wire logic                       system_clk_double,
    input  wire logic                       oscillatorClk,
    input  wire logic [`AMUX_PIN_CNT-1:0]   pinIn,
    output logic      [`AMUX_PIN_CNT-1:0]   pinOut,
    output logic      [`AMUX_PIN_CNT-1:0]   pinOe,
    output logic      [`AMUX_PIN_CNT-1:0]   pullupOn
);
    localparam int SYNC_W = `AMUX_PIN_CNT + UPPER_W + 3;
    localparam int LOW_W  = PORT_W - UPPER_W;

    // Software-visible state
    logic [PORT_W-1:0]   port_one_pullup_ctrl_reg;
    logic [PORT_W-1:0]   p1Dir_reg;
    logic [PORT_W-1:0]   p1Data_reg;
    logic [PORT_W-1:0]   p1Periph_reg;
    logic [PORT_W-1:0]   port_two_pullup_ctrl_reg;
    logic [PORT_W-1:0]   p2Dir_reg;
    logic [PORT_W-1:0]   p2Data_reg;
    logic [PORT_W-1:0]   port_two_periph_enable_reg;
    logic                bus_drive_keep_reg;
    logic [UPPER_W-1:0]  clock_output_select_reg;
    logic [`AMUX_DATA_W-1:0] rdData_reg;
    amux_pkg::amux_boot_t    bootState_reg;
    amux_pkg::amux_boot_t    bootState_next;

    // Two-stage synchronisers for pads, straps and monitored clocks
    logic [SYNC_W-1:0]   syncA_reg;
    logic [SYNC_W-1:0]   syncB_reg;
    logic [SYNC_W-1:0]   syncIn;

    logic [`AMUX_PIN_CNT-1:0] pinSync;
    logic [UPPER_W-1:0]       clkSync;
    logic                     bootSync;
    logic                     modeSync;
    logic                     secureSync;
    logic                     startAsAddr;

    logic wrP1Pullup;
    logic wrP1Dir;
    logic wrP1Data;
    logic wrP1Periph;
    logic wrP2Pullup;
    logic wrP2Dir;
    logic wrP2Data;
    logic wrP2Periph;
    logic wrBusCtrl;
    logic wrClkSel;
    logic selP1Pullup;
    logic selP1Dir;
    logic selP1Data;
    logic selP1Periph;
    logic selP1Pins;
    logic selP2Pullup;
    logic selP2Dir;
    logic selP2Data;
    logic selP2Periph;
    logic selP2Pins;
    logic selBusCtrl;
    logic selClkSel;
    logic [PORT_W-1:0]        wrByte;
    logic [PORT_W-1:0]        p2PeriphBoot;
    logic [PORT_W-1:0]        rdByte;
    logic [`AMUX_DATA_W-1:0]  rdMux;

    assign syncIn = {
        flashSecured,
        ext_bus_mode_input,
        external_boot_input,
        oscillatorClk,
        system_clk_double,
        system_clk_main,
        prescalerClk,
        pinIn
    };

    // No reset here: these only follow outside levels
    always_ff @(posedge clock) begin
        syncA_reg <= syncIn;
        syncB_reg <= syncA_reg;
    end

    assign pinSync    = syncB_reg[`AMUX_PIN_CNT-1:0];
    assign clkSync    = syncB_reg[`AMUX_PIN_CNT +: UPPER_W];
    assign bootSync   = syncB_reg[SYNC_W-3];
    assign modeSync   = syncB_reg[SYNC_W-2];
    assign secureSync = syncB_reg[SYNC_W-1];

    // Secured flash blocks only the bus-mode strap; the boot strap still selects address pins
    assign startAsAddr = bootSync | (modeSync & ~secureSync);

    // Index decode shared by both strobes
    assign selP1Pullup = (regAddr == `AMUX_OFS_P1_PULLUP);
    assign selP1Dir    = (regAddr == `AMUX_OFS_P1_DIR);
    assign selP1Data   = (regAddr == `AMUX_OFS_P1_DATA);
    assign selP1Periph = (regAddr == `AMUX_OFS_P1_PERIPH);
    assign selP1Pins   = (regAddr == `AMUX_OFS_P1_PINS);
    assign selP2Pullup = (regAddr == `AMUX_OFS_P2_PULLUP);
    assign selP2Dir    = (regAddr == `AMUX_OFS_P2_DIR);
    assign selP2Data   = (regAddr == `AMUX_OFS_P2_DATA);
    assign selP2Periph = (regAddr == `AMUX_OFS_P2_PERIPH);
    assign selP2Pins   = (regAddr == `AMUX_OFS_P2_PINS);
    assign selBusCtrl  = (regAddr == `AMUX_OFS_BUS_CTRL);
    assign selClkSel   = (regAddr == `AMUX_OFS_CLK_SEL);

    // Write decode; the pin-state indices have no write strobe
    assign wrByte     = regWrData[PORT_W-1:0];
    assign wrP1Pullup = regWrite & selP1Pullup;
    assign wrP1Dir    = regWrite & selP1Dir;
    assign wrP1Data   = regWrite & selP1Data;
    assign wrP1Periph = regWrite & selP1Periph;
    assign wrP2Pullup = regWrite & selP2Pullup;
    assign wrP2Dir    = regWrite & selP2Dir;
    assign wrP2Data   = regWrite & selP2Data;
    assign wrP2Periph = regWrite & selP2Periph;
    assign wrBusCtrl  = regWrite & selBusCtrl;
    assign wrClkSel   = regWrite & selClkSel;

    // Boot sequencing: one pass after reset release
    always_comb begin
        case (bootState_reg)
            amux_pkg::BOOT_PENDING: bootState_next = amux_pkg::BOOT_DONE;
            amux_pkg::BOOT_DONE:    bootState_next = amux_pkg::BOOT_DONE;
            default:                bootState_next = amux_pkg::BOOT_DONE;
        endcase
    end

    // A software write in the strap cycle wins over the strap choice
    always_comb begin
        p2PeriphBoot = port_two_periph_enable_reg;
        if (bootState_reg == amux_pkg::BOOT_PENDING) begin
            p2PeriphBoot[LOW_W-1:0] = {LOW_W{startAsAddr}};
        end
        if (wrP2Periph) begin
            p2PeriphBoot = wrByte;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bootState_reg <= amux_pkg::BOOT_PENDING;
            port_two_periph_enable_reg <= {`AMUX_P2_UPPER_RST,
                                           `AMUX_P2_LOWER_RST};
        end else begin
            bootState_reg <= bootState_next;
            port_two_periph_enable_reg <= p2PeriphBoot;
        end
    end

    // Pull-ups stay on until software clears them, so idle pads do not float before that
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            port_one_pullup_ctrl_reg <= `AMUX_PULLUP_RST;
        end else if (wrP1Pullup) begin
            port_one_pullup_ctrl_reg <= wrByte;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            port_two_pullup_ctrl_reg <= `AMUX_PULLUP_RST;
        end else if (wrP2Pullup) begin
            port_two_pullup_ctrl_reg <= wrByte;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            p1Periph_reg <= `AMUX_P1_PERIPH_RST;
        end else if (wrP1Periph) begin
            p1Periph_reg <= wrByte;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            p1Dir_reg <= `AMUX_DIR_RST;
        end else if (wrP1Dir) begin
            p1Dir_reg <= wrByte;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            p1Data_reg <= `AMUX_DATA_RST;
        end else if (wrP1Data) begin
            p1Data_reg <= wrByte;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            p2Dir_reg <= `AMUX_DIR_RST;
        end else if (wrP2Dir) begin
            p2Dir_reg <= wrByte;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            p2Data_reg <= `AMUX_DATA_RST;
        end else if (wrP2Data) begin
            p2Data_reg <= wrByte;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bus_drive_keep_reg <= `AMUX_DRV_RST;
        end else if (wrBusCtrl) begin
            bus_drive_keep_reg <= regWrData[`AMUX_DRV_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            clock_output_select_reg <= `AMUX_CLK_SEL_RST;
        end else if (wrClkSel) begin
            clock_output_select_reg <= regWrData[UPPER_W-1:0];
        end
    end

    // AND-OR read select: an unmapped index selects nothing and reads zero
    assign rdByte = ({PORT_W{selP1Pullup}} & port_one_pullup_ctrl_reg)
                  | ({PORT_W{selP1Dir}}    & p1Dir_reg)
                  | ({PORT_W{selP1Data}}   & p1Data_reg)
                  | ({PORT_W{selP1Periph}} & p1Periph_reg)
                  | ({PORT_W{selP1Pins}}   & pinSync[PORT_W-1:0])
                  | ({PORT_W{selP2Pullup}} & port_two_pullup_ctrl_reg)
                  | ({PORT_W{selP2Dir}}    & p2Dir_reg)
                  | ({PORT_W{selP2Data}}   & p2Data_reg)
                  | ({PORT_W{selP2Periph}} & port_two_periph_enable_reg)
                  | ({PORT_W{selP2Pins}}   & pinSync[`AMUX_PIN_CNT-1:PORT_W])
                  | ({PORT_W{selBusCtrl}}  & PORT_W'(bus_drive_keep_reg))
                  | ({PORT_W{selClkSel}}   & PORT_W'(clock_output_select_reg));
    // Port registers are a byte wide; the upper half of the word reads zero
    assign rdMux  = {{(`AMUX_DATA_W-PORT_W){1'b0}}, rdByte};

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdData_reg <= `AMUX_RD_ZERO;
        end else begin
            rdData_reg <= regRead ? rdMux : `AMUX_RD_ZERO;
        end
    end

    assign regRdData = rdData_reg;

    // Per-pin function select and pad drive
    logic [`AMUX_PIN_CNT-1:0] periphAll;
    logic [`AMUX_PIN_CNT-1:0] dirAll;
    logic [`AMUX_PIN_CNT-1:0] dataAll;
    logic [`AMUX_PIN_CNT-1:0] pullAll;
    logic [`AMUX_PIN_CNT-1:0] clkSelAll;
    logic [`AMUX_PIN_CNT-1:0] clkValAll;
    logic                     addrDrive;

    assign periphAll = {port_two_periph_enable_reg, p1Periph_reg};
    assign dirAll    = {p2Dir_reg, p1Dir_reg};
    assign dataAll   = {p2Data_reg, p1Data_reg};
    assign pullAll   = {port_two_pullup_ctrl_reg, port_one_pullup_ctrl_reg};
    assign clkSelAll = {clock_output_select_reg, 12'h000};
    assign clkValAll = {clkSync, 12'h000};
    // With drive-keep clear the lines float while the bus is idle
    assign addrDrive = extBusActive | bus_drive_keep_reg;

    genvar gi;
    generate
        for (gi = 0; gi < `AMUX_PIN_CNT; gi++) begin : g_pin
            amux_pin_if pinBus ();

            assign pinBus.func = !periphAll[gi] ? amux_pkg::FUNC_GPIO :
                                 clkSelAll[gi]  ? amux_pkg::FUNC_CLK  :
                                                  amux_pkg::FUNC_ADDR;
            assign pinBus.addrBit   = extAddr[gi+8];
            assign pinBus.addrDrive = addrDrive;
            assign pinBus.clkBit    = clkValAll[gi];
            assign pinBus.gpioDir   = dirAll[gi];
            assign pinBus.gpioData  = dataAll[gi];
            assign pinBus.pullCtrl  = pullAll[gi];

            amux_pin_slice u_slice (
                .clock (clock),
                .rst_n (rst_n),
                .pin   (pinBus.slice)
            );

            assign pinOut[gi]   = pinBus.pinOut;
            assign pinOe[gi]    = pinBus.pinOe;
            assign pullupOn[gi] = pinBus.pullOn;
        end
    endgenerate
endmodule // amux_pin_mux

// >>> bench/amux_mem_model.sv
module amux_mem_model (
    input  wire logic        clock,
    input  wire logic [15:0] pinOut,
    input  wire logic [15:0] pinOe,
    input  wire logic [15:0] pullupOn,
    output logic      [15:0] padLevel
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] lastLevel = 16'h0000;
    // A floating pad flips every cycle so an undriven read is never lucky
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (pinOe[i])
                padLevel[i] = pinOut[i];
            else if (pullupOn[i])
                padLevel[i] = 1'b1;
            else
                padLevel[i] = ~lastLevel[i];
        end
    end
    always @(posedge clock) lastLevel <= padLevel;
endmodule // amux_mem_model

// >>> bench/amux_pin_mux_assertions.sv
`include "amux_defs.svh"

module amux_pin_mux_assertions (
    input wire logic                     clock,
    input wire logic                     rst_n,
    input wire logic [`AMUX_ADDR_W-1:0]  regAddr,
    input wire logic [`AMUX_DATA_W-1:0]  regWrData,
    input wire logic                     regWrite,
    input wire logic [23:8]              extAddr,
    input wire logic                     extBusActive,
    input wire logic                     external_boot_input,
    input wire logic                     ext_bus_mode_input,
    input wire logic                     flashSecured,
    input wire logic [`AMUX_PIN_CNT-1:0] pinOut,
    input wire logic [`AMUX_PIN_CNT-1:0] pinOe,
    input wire logic [`AMUX_PIN_CNT-1:0] pullupOn
);
    timeunit 1ns;
    timeprecision 100ps;
    logic cfgDefault;
    // Only before the first write is the pin setup known without a model
    always_ff @(posedge clock) begin
        if (!rst_n)
            cfgDefault <= 1'b1;
        else if (regWrite)
            cfgDefault <= 1'b0;
    end
    wire logic quiet = cfgDefault && !regWrite;
    wire logic strapAddr = external_boot_input
                         | (ext_bus_mode_input & ~flashSecured);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_rst_quiet;
        disable iff (1'b0)
        !rst_n ##1 !rst_n |-> pinOe == 16'h0000 && pullupOn == 16'hFFFF;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("pads active during reset");
    property p_addr_dflt;
        quiet && extBusActive |=> pinOe[7:0] == 8'hFF
            && pinOut[7:0] == $past(extAddr[15:8]);
    endproperty
    a_addr_dflt: assert property (p_addr_dflt)
        else $error("port one not in address function");
    property p_idle_tri;
        quiet && !extBusActive |=> pinOe[7:0] == 8'h00;
    endproperty
    a_idle_tri: assert property (p_idle_tri)
        else $error("address pins driven on idle bus");
    property p_upper_gpio;
        quiet |=> pinOe[15:12] == 4'h0;
    endproperty
    a_upper_gpio: assert property (p_upper_gpio)
        else $error("upper pins not plain inputs");
    property p_pull_dflt;
        quiet |=> pullupOn == 16'hFFFF;
    endproperty
    a_pull_dflt: assert property (p_pull_dflt)
        else $error("pull-ups off before any write");
    property p_strap;
        $rose(rst_n) ##1 (quiet && extBusActive)
            |=> pinOe[11:8] == {4{strapAddr}};
    endproperty
    a_strap: assert property (p_strap)
        else $error("lower port two startup wrong");
    property p_pull_one;
        regWrite && regAddr == `AMUX_OFS_P1_PULLUP
            |=> ##1 pullupOn[7:0] == $past(regWrData[7:0], 2);
    endproperty
    a_pull_one: assert property (p_pull_one)
        else $error("port one pull-up mismatch");
    property p_pull_two;
        regWrite && regAddr == `AMUX_OFS_P2_PULLUP
            |=> ##1 pullupOn[15:8] == $past(regWrData[7:0], 2);
    endproperty
    a_pull_two: assert property (p_pull_two)
        else $error("port two pull-up mismatch");
endmodule // amux_pin_mux_assertions

bind amux_pin_mux amux_pin_mux_assertions u_chk (
    .clock(clock), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .extAddr(extAddr),
    .extBusActive(extBusActive),
    .external_boot_input(external_boot_input),
    .ext_bus_mode_input(ext_bus_mode_input),
    .flashSecured(flashSecured), .pinOut(pinOut), .pinOe(pinOe),
    .pullupOn(pullupOn)
);

// >>> bench/tb_address_gpio_pin_mux.sv
module tb_address_gpio_pin_mux;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [23:8] extAddr = 16'h0000;
    logic        extBusActive = 1'b0;
    logic        bootIn = 1'b0;
    logic        modeIn = 1'b0;
    logic        secured = 1'b0;
    logic [4:0]  clkCnt = 5'h00;
    logic [15:0] regRdData, pinIn, pinOut, pinOe, pullupOn;
    int          error_cnt = 0;
    int          compares = 0;

    initial forever #12.5 clock = ~clock;
    always @(posedge clock) clkCnt <= clkCnt + 5'h01;

    amux_pin_mux DUT (
        .clock(clock), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .extAddr(extAddr),
        .extBusActive(extBusActive), .external_boot_input(bootIn),
        .ext_bus_mode_input(modeIn), .flashSecured(secured),
        .prescalerClk(clkCnt[2]), .system_clk_main(clkCnt[3]),
        .system_clk_double(clkCnt[1]), .oscillatorClk(clkCnt[4]),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pullupOn(pullupOn)
    );
    amux_mem_model u_mem (
        .clock(clock), .pinOut(pinOut), .pinOe(pinOe),
        .pullupOn(pullupOn), .padLevel(pinIn)
    );

    task automatic chk(input string name, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    task automatic rdChk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        @(negedge clock);
        chk("read data", regRdData, exp);
    endtask
    task automatic settle;
        repeat (3) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic do_reset(input logic b, m, s);
        @(posedge clock);
        rst_n <= 1'b0;
        bootIn <= b;
        modeIn <= m;
        secured <= s;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
    endtask

    task automatic t_defaults;
        do_reset(1'b1, 1'b0, 1'b0);
        extBusActive <= 1'b1;
        extAddr <= 16'hA5C3;
        settle();
        chk("oe", pinOe, 16'h0FFF);
        chk("out", {4'h0, pinOut[11:0]}, {4'h0, extAddr[19:8]});
        chk("pull", pullupOn, 16'hFFFF);
        rdChk(4'h0, 16'h00FF);
        rdChk(4'h5, 16'h00FF);
    endtask
    task automatic t_straps;
        logic [15:0] lo;
        for (int k = 0; k < 8; k++) begin
            do_reset(k[2], k[1], k[0]);
            lo = (k[2] | (k[1] & ~k[0])) ? 16'h000F : 16'h0000;
            rdChk(4'h8, lo);
            wr(4'h8, lo ^ 16'h000F);
            rdChk(4'h8, lo ^ 16'h000F);
        end
    endtask
    task automatic t_pullups;
        wr(4'h0, 16'h00FE);
        wr(4'h5, 16'h007F);
        settle();
        chk("pull", pullupOn, 16'h7FFE);
    endtask
    task automatic t_drive;
        extBusActive <= 1'b0;
        settle();
        chk("idle oe", {8'h00, pinOe[7:0]}, 16'h0000);
        wr(4'hA, 16'h0001);
        settle();
        chk("keep oe", {8'h00, pinOe[7:0]}, 16'h00FF);
        wr(4'hA, 16'h0000);
    endtask
    task automatic t_gpio;
        wr(4'h3, 16'h0000);
        wr(4'h1, 16'h000F);
        wr(4'h2, 16'h0005);
        settle();
        chk("gpio oe", {8'h00, pinOe[7:0]}, 16'h000F);
        chk("gpio out", {12'h000, pinOut[3:0]}, 16'h0005);
        rdChk(4'h4, 16'h00F5);
        wr(4'h3, 16'h00FF);
        settle();
        chk("addr oe", {8'h00, pinOe[7:0]}, 16'h0000);
    endtask
    task automatic t_upper;
        logic [3:0]  prev;
        logic [15:0] tog [4];
        wr(4'hA, 16'h0001);
        wr(4'h8, 16'h00F0);
        wr(4'h6, 16'h0003);
        wr(4'h7, 16'h0001);
        extAddr <= 16'h5A00;
        settle();
        chk("upper oe", {12'h000, pinOe[15:12]}, 16'h000F);
        chk("upper addr", {12'h000, pinOut[15:12]}, 16'h0005);
        chk("p2 gpio oe", {12'h000, pinOe[11:8]}, 16'h0003);
        rdChk(4'h9, 16'h005D);
        wr(4'hB, 16'h000F);
        settle();
        tog = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
        prev = pinOut[15:12];
        repeat (32) begin
            @(negedge clock);
            for (int j = 0; j < 4; j++)
                if (pinOut[12 + j] !== prev[j])
                    tog[j]++;
            prev = pinOut[15:12];
        end
        chk("prescaler", tog[0], 16'h0008);
        chk("system", tog[1], 16'h0004);
        chk("double", tog[2], 16'h0010);
        chk("oscillator", tog[3], 16'h0002);
        wr(4'h8, 16'h00B0);
        settle();
        chk("per-pin oe", {12'h000, pinOe[15:12]}, 16'h000B);
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge clock);
        error_cnt++;
        conclude();
    end
    initial begin
        t_defaults();
        t_straps();
        t_pullups();
        t_drive();
        t_gpio();
        t_upper();
        conclude();
    end
endmodule // tb_address_gpio_pin_mux
